// *** logic/pmr_ctrl.sv ***
/*
 Palette mode, reset and sync front end: APB registers, three reset
 sources, shift and video clock dividers, pixel latching, read mask,
 palette lookup, sync polarity and sync pipeline.
 Assumes every pin input is synchronous to clock; the dot clock and the
 pass-through clock arrive as one-cycle enable pulses.
*/
`timescale 1ns/100ps
`include "pmr_defs.svh"

// Contract
// RQ1: mux code 1Eh gives 8-bit pixels, 32-bit bus, bytes shown low first.
// RQ2: host writes 12h to output clock select for 1:4 shift ratio.
// RQ3: mux code 2Dh puts the block into pass-through mode.
// RQ4: writing 2Dh to mux bits 5:0 resets every register to default.
// RQ5: palette address is masked after the page is added.
// RQ6: every reset source clears both dividers and selects pass-through.
// RQ7: power-on reset leaves the block in pass-through mode.
// RQ8: write strobe rising with all selects high is a hardware reset.
// RQ9: host repeats such strobes while the supply settles.
// RQ10: reset values 2Dh, 00h, 3Fh, 00h, 03h, FFh.
// RQ11: after reset the test register selects the red component.
// RQ12: pixels latched on shift clock, or pass-through clock in that mode.
// RQ13: syncs sampled on video clock fall, or pass-through clock.
// RQ14: syncs and video-off are delayed to stay aligned with pixels.
// RQ15: general control bit 4 selects the 7.5 IRE pedestal.
// RQ16: normal syncs pass true or inverted, pass-through ones unchanged.
// RQ17: sync polarity bits reset to one, act only in normal modes.
// RQ18: an active sync turns off the green sync current.
// RQ19: frame buffer drives syncs only while video-off is active.
// RQ20: system tolerates shift pulses after video-off goes active.
// RQ21: system muxes sync inputs using the external select output; the bench feeds one sync source to both modes.
// RQ22: mux bits 6 and 7 are ignored.
// RQ23: masked address indexes the palette, colour aligned with syncs.
module pmr_ctrl
   import pmr_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // host strobe pins
   input  wire logic [3:0]  register_select,
   input  wire logic        wr_strobe,
   // clock enables
   input  wire logic        pixel_rate_clock,
   input  wire logic        passthrough_clock_in,
   // frame buffer side
   input  wire logic [31:0] pixel_in,
   input  wire logic [7:0]  vga_pixel_in,
   input  wire logic        hsync_n_in,
   input  wire logic        vsync_n_in,
   input  wire logic        video_off_n_in,
   input  wire logic        passthrough_video_off_n_in,
   output logic             shift_clock_out,
   output logic             video_clock_out,
   // output stage
   output logic      [7:0]  red_out,
   output logic      [7:0]  green_out,
   output logic      [7:0]  blue_out,
   output logic             horizontal_sync_out,
   output logic             vertical_sync_out,
   output logic             green_current_output,
   output logic             pedestal_out,
   output logic             video_off_n_out,
   output logic             external_select_out
);
   logic [7:0]  mux_reg, inclk_reg, outclk_reg, page_reg;
   logic [7:0]  gen_reg, mask_reg, pal_addr_reg;
   pmr_comp_t   test_reg;
   logic        strobe_reg;
   logic [3:0]  vcnt_reg, scnt_reg;
   logic [31:0] word_reg;
   logic [1:0]  byte_idx_reg;
   logic [2:0]  samp_reg;
   logic        tick_d_reg;
   logic [23:0] shown_reg;
   logic [23:0] pal_rd_data;
   logic [2:0]  dly;

   // register bus decode
   wire         acc    = psel & penable & pready;
   wire         hit    = (paddr[1:0] == 2'h0) &&
                         (paddr <= `PMR_A_STATUS);
   wire         wr_ok  = acc & pwrite & ~pslverr;
   wire         wr_mux = wr_ok & (paddr == `PMR_A_MUX);
   wire         wr_pal = wr_ok & (paddr == `PMR_A_PALDATA);

   // RQ4 soft reset on pass-through code
   wire         sw_rst = wr_mux & (pwdata[5:0] == `PMR_MUX_PT);
   // RQ8 strobe edge reset
   wire         hw_rst = wr_strobe & ~strobe_reg &
                         (register_select == `PMR_HWRST_SEL);
   // RQ6 RQ7 all reset sources merged
   wire         clr    = ~rst_n | hw_rst | sw_rst;

   // RQ22 only bits 5:0 decode
   wire [5:0]   mux_sel = mux_reg[5:0];
   // RQ3 pass-through decode
   wire         pt_mode = (mux_sel == `PMR_MUX_PT);
   pmr_mode_t   mode;
   // RQ1 mode and bytes per load
   assign mode = pt_mode ? PMR_M_PT :
                 (mux_sel == `PMR_MUX_8B32) ? PMR_M_8X4 :
                 (mux_sel == `PMR_MUX_8B16) ? PMR_M_8X2 : PMR_M_8X1;
   wire [1:0]   byte_last = (mode == PMR_M_8X4) ? 2'h3 :
                            (mode == PMR_M_8X2) ? 2'h1 : 2'h0;

   always_ff @(posedge clock) begin
      // RQ10 RQ11 RQ17 defaults
      if (clr) begin
         mux_reg      <= `PMR_RV_MUX;
         inclk_reg    <= `PMR_RV_INCLK;
         outclk_reg   <= `PMR_RV_OUTCLK;
         page_reg     <= `PMR_RV_PAGE;
         gen_reg      <= `PMR_RV_GEN;
         mask_reg     <= `PMR_RV_MASK;
         test_reg     <= PMR_CMP_RED;
         pal_addr_reg <= 8'h00;
      end else if (wr_ok) begin
         case (paddr)
            `PMR_A_MUX:     mux_reg    <= pwdata[7:0];
            `PMR_A_INCLK:   inclk_reg  <= pwdata[7:0];
            `PMR_A_OUTCLK:  outclk_reg <= pwdata[7:0];
            `PMR_A_PAGE:    page_reg   <= pwdata[7:0];
            `PMR_A_GEN:     gen_reg    <= pwdata[7:0];
            `PMR_A_MASK:    mask_reg   <= pwdata[7:0];
            `PMR_A_TEST:    test_reg   <= pmr_comp_t'(pwdata[1:0]);
            `PMR_A_PALADDR: pal_addr_reg <= pwdata[7:0];
            `PMR_A_PALDATA: pal_addr_reg <= 8'(pal_addr_reg + 8'h01);
            default: ;
         endcase
      end
   end

   // read data; the test register picks one component of the shown colour
   wire [7:0]   test_cmp = (test_reg == PMR_CMP_RED)   ? shown_reg[23:16] :
                           (test_reg == PMR_CMP_GREEN) ? shown_reg[15:8] :
                           shown_reg[7:0];
   wire [31:0]  status = {16'h0000, test_cmp, 5'h00, pt_mode, samp_reg[1:0]};
   logic [31:0] prdata_next;
   always_comb begin
      prdata_next = 32'h0000_0000;
      case (paddr)
         `PMR_A_MUX:     prdata_next[7:0] = mux_reg;
         `PMR_A_INCLK:   prdata_next[7:0] = inclk_reg;
         `PMR_A_OUTCLK:  prdata_next[7:0] = outclk_reg;
         `PMR_A_PAGE:    prdata_next[7:0] = page_reg;
         `PMR_A_GEN:     prdata_next[7:0] = gen_reg;
         `PMR_A_MASK:    prdata_next[7:0] = mask_reg;
         `PMR_A_TEST:    prdata_next[1:0] = test_reg;
         `PMR_A_PALADDR: prdata_next[7:0] = pal_addr_reg;
         `PMR_A_STATUS:  prdata_next      = status;
         default:        prdata_next      = 32'h0000_0000;
      endcase
   end

   // answer in the first access cycle; read data caught at setup
   always_ff @(posedge clock) begin
      if (~rst_n) begin
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         prdata     <= 32'h0000_0000;
         strobe_reg <= 1'b0;
      end else begin
         pready     <= psel & ~penable;
         pslverr    <= psel & ~penable & ~hit;
         strobe_reg <= wr_strobe;
         if (psel & ~penable) begin
            prdata <= prdata_next;
         end
      end
   end

   // clock dividers; codes above the limit hold the clock still
   wire [2:0]   vcode = outclk_reg[2:0];
   wire [2:0]   scode = outclk_reg[5:3];
   wire         vrun  = (vcode <= `PMR_DIV_MAXCODE);
   wire         srun  = (scode <= `PMR_DIV_MAXCODE);
   wire [3:0]   vdiv  = 4'h1 << vcode[1:0];
   wire [3:0]   sdiv  = 4'h1 << scode[1:0];
   wire [3:0]   vlast = 4'(vdiv - 4'h1);
   wire [3:0]   slast = 4'(sdiv - 4'h1);
   wire         dot   = pixel_rate_clock;
   wire         v_rise = dot & vrun & (vcnt_reg == 4'h0);
   wire         v_fall = dot & vrun & (vcnt_reg == (vdiv >> 1));
   wire         s_rise = dot & srun & (scnt_reg == 4'h0) & ~pt_mode;

   always_ff @(posedge clock) begin
      // RQ6 dividers cleared by every reset
      if (clr) begin
         vcnt_reg        <= 4'h0;
         scnt_reg        <= 4'h0;
         video_clock_out <= 1'b0;
         shift_clock_out <= 1'b0;
      end else begin
         video_clock_out <= v_rise;
         shift_clock_out <= s_rise;
         if (dot & vrun) begin
            vcnt_reg <= (vcnt_reg >= vlast) ? 4'h0 : 4'(vcnt_reg + 4'h1);
         end
         if (dot & srun) begin
            scnt_reg <= (scnt_reg >= slast) ? 4'h0 : 4'(scnt_reg + 4'h1);
         end
      end
   end

   // RQ12 pixel tick and byte choice
   wire         pix_tick = pt_mode ? passthrough_clock_in : dot;
   wire [31:0]  word_sh  = word_reg >> {byte_idx_reg, 3'h0};
   wire [7:0]   cur_byte = pt_mode ? vga_pixel_in :
                           s_rise  ? pixel_in[7:0] : word_sh[7:0];
   // RQ5 mask applied after the page bits
   wire [7:0]   pal_rd_addr = (cur_byte | page_reg) & mask_reg;

   always_ff @(posedge clock) begin
      // RQ1 whole bus latched, bytes shifted out low first
      if (clr) begin
         word_reg     <= 32'h0000_0000;
         byte_idx_reg <= 2'h0;
      end else if (s_rise) begin
         word_reg     <= pixel_in;
         byte_idx_reg <= (byte_last == 2'h0) ? 2'h0 : 2'h1;
      end else if (~pt_mode & dot) begin
         byte_idx_reg <= (byte_idx_reg >= byte_last) ? 2'h0 :
                         2'(byte_idx_reg + 2'h1);
      end
   end

   // RQ23 palette lookup per pixel tick
   pmr_palette_mem u_mem (
      .clock   (clock),
      .wr_en   (wr_pal),
      .wr_addr (pal_addr_reg),
      .wr_data (pwdata[23:0]),
      .rd_en   (pix_tick),
      .rd_addr (pal_rd_addr),
      .rd_data (pal_rd_data)
   );

   // RQ13 control sampling point depends on mode
   wire         samp_en  = pt_mode ? passthrough_clock_in : v_fall;
   wire         off_n_in = pt_mode ? passthrough_video_off_n_in :
                                     video_off_n_in;
   always_ff @(posedge clock) begin
      if (clr) begin
         samp_reg <= 3'h7;
      end else if (samp_en) begin
         samp_reg <= {off_n_in, hsync_n_in, vsync_n_in};
      end
   end

   // RQ14 controls ride the pixel pipeline
   pmr_delay_pipe #(.W(3), .D(`PMR_PIPE_DEPTH)) u_pipe (
      .clock (clock),
      .clr   (clr),
      .en    (pix_tick),
      .din   (samp_reg),
      .dout  (dly)
   );

   wire         dly_off_n = dly[2];
   wire         dly_hs_n  = dly[1];
   wire         dly_vs_n  = dly[0];
   // RQ16 RQ17 polarity only outside pass-through
   wire         hs_next = pt_mode ? dly_hs_n :
                          (gen_reg[`PMR_G_HPOL] ? ~dly_hs_n : dly_hs_n);
   wire         vs_next = pt_mode ? dly_vs_n :
                          (gen_reg[`PMR_G_VPOL] ? ~dly_vs_n : dly_vs_n);
   // RQ18 sync current off while any sync is active
   wire         cur_next = gen_reg[`PMR_G_SYNCEN] & dly_hs_n & dly_vs_n;
   wire [23:0]  rgb_next = dly_off_n ? pal_rd_data : 24'h00_0000;

   always_ff @(posedge clock) begin
      if (clr) begin
         tick_d_reg           <= 1'b0;
         shown_reg            <= 24'h00_0000;
         red_out              <= 8'h00;
         green_out            <= 8'h00;
         blue_out             <= 8'h00;
         horizontal_sync_out  <= 1'b1;
         vertical_sync_out    <= 1'b1;
         green_current_output <= 1'b0;
         video_off_n_out      <= 1'b0;
         pedestal_out         <= 1'b0;
         external_select_out  <= 1'b0;
      end else begin
         tick_d_reg           <= pix_tick;
         // RQ15 pedestal select
         pedestal_out         <= gen_reg[`PMR_G_PED];
         external_select_out  <= pt_mode ? 1'b0 : gen_reg[`PMR_G_SELOUT];
         if (tick_d_reg) begin
            shown_reg            <= rgb_next;
            red_out              <= rgb_next[23:16];
            green_out            <= rgb_next[15:8];
            blue_out             <= rgb_next[7:0];
            horizontal_sync_out  <= hs_next;
            vertical_sync_out    <= vs_next;
            green_current_output <= cur_next;
            video_off_n_out      <= dly_off_n;
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (~rst_n);

   AST_SWRST_DEFAULTS: assert property ( // RQ4
      sw_rst |=> (mux_reg == 8'h2D) && (gen_reg == 8'h03) &&
                 (mask_reg == 8'hFF) && (test_reg == PMR_CMP_RED))
      else $error("soft reset did not restore defaults");
   AST_HWRST_DEFAULTS: assert property ( // RQ8
      hw_rst |=> (outclk_reg == 8'h3F) && (page_reg == 8'h00) && pt_mode)
      else $error("strobe reset did not restore defaults");
   AST_DIV_CLEAR: assert property ( // RQ6
      (hw_rst || sw_rst) |=> (vcnt_reg == 4'h0) && (scnt_reg == 4'h0))
      else $error("dividers not cleared by reset");
   AST_MASK_ZERO: assert property ( // RQ5
      (mask_reg == 8'h00) && pix_tick |-> (pal_rd_addr == 8'h00))
      else $error("zero mask did not select location zero");
   AST_WORD_LATCH: assert property ( // RQ1
      (s_rise && mode == PMR_M_8X4 && !clr) |=>
      (word_reg == $past(pixel_in)) && (byte_idx_reg == 2'h1))
      else $error("bus word not latched on shift clock");
   AST_SAMPLE_HOLD: assert property ( // RQ13
      (!pt_mode && !v_fall && !clr) |=> $stable(samp_reg))
      else $error("controls sampled off the video clock fall");
   AST_PT_SYNC_TRUE: assert property ( // RQ16
      (tick_d_reg && pt_mode && !clr) |=>
      (horizontal_sync_out == $past(dly_hs_n)))
      else $error("pass-through sync altered");
   AST_NORMAL_POL: assert property ( // RQ17
      (tick_d_reg && !pt_mode && gen_reg[0] && !clr) |=>
      (horizontal_sync_out == !$past(dly_hs_n)))
      else $error("normal sync polarity not applied");
   AST_SYNC_CURRENT: assert property ( // RQ18
      (tick_d_reg && !dly_vs_n && !clr) |=> !green_current_output)
      else $error("sync current on during active sync");
   AST_SELECT_LOW: assert property ( // RQ3
      (pt_mode && !clr) |=> !external_select_out)
      else $error("external select high in pass-through");
endmodule // pmr_ctrl

// *** logic/pmr_defs.svh ***
/*
 Register offsets, field positions, reset values and mode codes of the
 palette mode, reset and sync front end.
 Assumes inclusion by bare name from the design files.
*/
`ifndef PMR_DEFS_SVH
`define PMR_DEFS_SVH

// register byte addresses on the APB
`define PMR_A_MUX      12'h000
`define PMR_A_INCLK    12'h004
`define PMR_A_OUTCLK   12'h008
`define PMR_A_PAGE     12'h00C
`define PMR_A_GEN      12'h010
`define PMR_A_MASK     12'h014
`define PMR_A_TEST     12'h018
`define PMR_A_PALADDR  12'h01C
`define PMR_A_PALDATA  12'h020
`define PMR_A_STATUS   12'h024

// reset values
`define PMR_RV_MUX     8'h2D
`define PMR_RV_INCLK   8'h00
`define PMR_RV_OUTCLK  8'h3F
`define PMR_RV_PAGE    8'h00
`define PMR_RV_GEN     8'h03
`define PMR_RV_MASK    8'hFF

// multiplex control codes (bits 5:0)
`define PMR_MUX_PT     6'h2D
`define PMR_MUX_8B32   6'h1E
`define PMR_MUX_8B16   6'h1D

// general control fields
`define PMR_G_HPOL     0
`define PMR_G_VPOL     1
`define PMR_G_PED      4
`define PMR_G_SYNCEN   5
`define PMR_G_SELOUT   7

// hardware reset select pattern
`define PMR_HWRST_SEL  4'hF

// highest divider code that runs; larger codes hold the clock
`define PMR_DIV_MAXCODE 3'h3

// pixel tick stages between sync sampling and the output stage
`define PMR_PIPE_DEPTH 2

`endif

// *** logic/pmr_delay_pipe.sv ***
/*
 Enabled delay line for the sync and video-off controls.
 Assumes a synchronous clear and one enable pulse per pixel.
*/
`timescale 1ns/100ps
module pmr_delay_pipe
   import pmr_pkg::*;
#(
   parameter int W = 3,
   parameter int D = 2
)(
   // clock and clear
   input  wire logic         clock,
   input  wire logic         clr,
   // data
   input  wire logic         en,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] stage_reg [0:D-1];

   genvar i;
   generate
      for (i = 0; i < D; i++) begin : g_stage
         always_ff @(posedge clock) begin
            // clear to inactive (all ones: controls are active low)
            if (clr) begin
               stage_reg[i] <= {W{1'b1}};
            end else if (en) begin
               stage_reg[i] <= (i == 0) ? din : stage_reg[(i == 0) ? 0 : i-1];
            end
         end
      end
   endgenerate

   assign dout = stage_reg[D-1];
endmodule // pmr_delay_pipe

// *** logic/pmr_palette_mem.sv ***
/*
 Colour lookup memory, 256 words of 24 bits, one write and one read port.
 Assumes a single clock; read data is registered.
*/
`timescale 1ns/100ps
module pmr_palette_mem
   import pmr_pkg::*;
(
   // clock
   input  wire logic        clock,
   // write port
   input  wire logic        wr_en,
   input  wire logic [7:0]  wr_addr,
   input  wire logic [23:0] wr_data,
   // read port
   input  wire logic        rd_en,
   input  wire logic [7:0]  rd_addr,
   output logic      [23:0] rd_data
);
   logic [23:0] mem [0:255];

   always_ff @(posedge clock) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule // pmr_palette_mem

// *** logic/pmr_pkg.sv ***
/*
 Types of the palette mode, reset and sync front end.
 Assumes nothing of its surroundings.
*/
package pmr_pkg;
   typedef enum logic [1:0] {
      PMR_CMP_RED   = 2'h0,
      PMR_CMP_GREEN = 2'h1,
      PMR_CMP_BLUE  = 2'h2
   } pmr_comp_t;

   typedef enum logic [1:0] {
      PMR_M_PT   = 2'h0,
      PMR_M_8X1  = 2'h1,
      PMR_M_8X2  = 2'h3,
      PMR_M_8X4  = 2'h2
   } pmr_mode_t;
endpackage

// *** test/pmr_fb_model.sv ***
/*
 Frame buffer model facing the pixel and sync pins of pmr_ctrl.
 Assumes the bench supplies the next bus word and the sync requests.
*/
`timescale 1ns/100ps
module pmr_fb_model (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // device side
   input  wire logic        shift_clock_out,
   output logic      [31:0] pixel_in,
   output logic             hsync_n_in,
   output logic             vsync_n_in,
   output logic             video_off_n_in,
   // bench side
   input  wire logic [31:0] next_word,
   input  wire logic        hs_req,
   input  wire logic        vs_req,
   input  wire logic        off_req
);
   // late shift pulses: a word is still offered, nothing stalls
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pixel_in <= 32'h0;
      end else if (shift_clock_out) begin
         pixel_in <= next_word;
      end
   end
   // syncs only inside video-off, one sync source for both modes
   always_ff @(posedge clock) begin
      hsync_n_in     <= ~(hs_req & off_req);
      vsync_n_in     <= ~(vs_req & off_req);
      video_off_n_in <= ~off_req;
   end
endmodule // pmr_fb_model

// *** test/tb.sv ***
/*
 Self-checking bench of pmr_ctrl: APB registers, resets, pixel and sync.
 Assumes pmr_fb_model and the design files are compiled first.
*/
`timescale 1ns/100ps
`include "pmr_defs.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
   $display("ERROR %s expected %h seen %h", nm, e, g); \
   error_cnt++; end end
module tb;
   import pmr_pkg::*;
   logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, pixel_in, next_word = 32'h0;
   logic pready, pslverr, wr_strobe = 0, dot_run = 0, pt_run = 0;
   logic [3:0] register_select = 4'h0;
   logic pixel_rate_clock = 0, passthrough_clock_in = 0;
   logic [7:0] vga_pixel_in = 8'h0, red_out, green_out, blue_out;
   logic passthrough_video_off_n_in = 1, hs_req = 0, vs_req = 0;
   logic off_req = 0, hsync_n_in, vsync_n_in, video_off_n_in;
   logic shift_clock_out, video_clock_out, horizontal_sync_out;
   logic vertical_sync_out, green_current_output, pedestal_out;
   logic video_off_n_out, external_select_out;
   int error_cnt = 0, tests_run = 0, cyc = 0;

   pmr_ctrl u_pmr_ctrl (.*);
   pmr_fb_model u_pmr_fb_model (.*);

   always #5 clock = ~clock;
   always @(posedge clock) begin
      pixel_rate_clock <= dot_run;
      passthrough_clock_in <= pt_run;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         `CHK("cycle_limit", 1'b0, 1'b1)
         summarize();
      end
   end

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      int n;
      @(posedge clock);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      `CHK("apb_wait", 1, n)
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input string nm, input logic [11:0] a,
                     input logic [31:0] x);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      `CHK(nm, x, q)
   endtask
   task automatic strobe(input logic [3:0] s);
      @(posedge clock);
      register_select <= s;
      @(posedge clock);
      wr_strobe <= 1;
      repeat (2) @(posedge clock);
      wr_strobe <= 0;
   endtask

   task automatic t_reset;
      logic [31:0] q;
      logic e;
      rd("mux", `PMR_A_MUX, 32'h2D);
      rd("inclk", `PMR_A_INCLK, 32'h00);
      rd("outclk", `PMR_A_OUTCLK, 32'h3F);
      rd("page", `PMR_A_PAGE, 32'h00);
      rd("gen", `PMR_A_GEN, 32'h03);
      rd("mask", `PMR_A_MASK, 32'hFF);
      rd("test", `PMR_A_TEST, 32'h00);
      `CHK("sel_pt", 1'b0, external_select_out)
      apb(1'b0, 12'h030, 32'h0, q, e);
      `CHK("unmapped_err", 1'b1, e)
      `CHK("unmapped_data", 32'h0, q)
   endtask
   task automatic t_soft_reset;
      wr(`PMR_A_PAGE, 32'h55);
      wr(`PMR_A_MASK, 32'h0F);
      wr(`PMR_A_GEN, 32'h13);
      repeat (2) @(posedge clock);
      `CHK("pedestal_on", 1'b1, pedestal_out)
      // upper bits set: still counts as the pass-through code
      wr(`PMR_A_MUX, 32'hED);
      rd("page_sr", `PMR_A_PAGE, 32'h00);
      rd("mask_sr", `PMR_A_MASK, 32'hFF);
      rd("gen_sr", `PMR_A_GEN, 32'h03);
      `CHK("pedestal_off", 1'b0, pedestal_out)
   endtask
   task automatic t_hw_reset;
      wr(`PMR_A_PAGE, 32'h33);
      strobe(4'hE);
      rd("page_keep", `PMR_A_PAGE, 32'h33);
      strobe(4'hF);
      strobe(4'hF);
      rd("page_hw", `PMR_A_PAGE, 32'h00);
      rd("outclk_hw", `PMR_A_OUTCLK, 32'h3F);
   endtask
   task automatic t_normal;
      logic [7:0] s[$];
      int k, nv, ns;
      wr(`PMR_A_PALADDR, 32'h00);
      wr(`PMR_A_PALDATA, 32'h00C51122);
      wr(`PMR_A_PALADDR, 32'h10);
      for (int i = 0; i < 4; i++) begin
         wr(`PMR_A_PALDATA, {8'h00, 8'hA0 + 8'(i), 16'h4050});
      end
      next_word <= 32'h13121110;
      wr(`PMR_A_OUTCLK, 32'h12);
      wr(`PMR_A_MUX, 32'h1E);
      wr(`PMR_A_GEN, 32'hA3);
      dot_run <= 1;
      k = -1;
      nv = 0;
      ns = 0;
      for (int i = 0; i < 40; i++) begin
         @(posedge clock);
         s.push_back(red_out);
         nv += int'(video_clock_out === 1'b1);
         ns += int'(shift_clock_out === 1'b1);
         if (k < 0 && red_out === 8'hA0 && i < 37) k = i;
      end
      `CHK("sel_normal", 1'b1, external_select_out)
      `CHK("green", 8'h40, green_out)
      `CHK("blue", 8'h50, blue_out)
      `CHK("video_clock_rate", 10, nv)
      `CHK("sclk_rate", 10, ns)
      `CHK("byte0_seen", 1'b1, k >= 0)
      if (k >= 0) begin
         `CHK("byte1", 8'hA1, s[k + 1])
         `CHK("byte2", 8'hA2, s[k + 2])
         `CHK("byte3", 8'hA3, s[k + 3])
      end
      wr(`PMR_A_MASK, 32'h00);
      wr(`PMR_A_PAGE, 32'hF0);
      repeat (16) @(posedge clock);
      `CHK("mask_zero", 8'hC5, red_out)
   endtask
   task automatic t_sync;
      // pipeline plus a full video clock period fits well inside 16 cycles
      off_req <= 1;
      hs_req <= 1;
      repeat (16) @(posedge clock);
      `CHK("hs_high", 1'b1, horizontal_sync_out)
      `CHK("vs_idle", 1'b0, vertical_sync_out)
      `CHK("cur_off", 1'b0, green_current_output)
      `CHK("off_out", 1'b0, video_off_n_out)
      `CHK("rgb_off", 8'h00, red_out)
      wr(`PMR_A_GEN, 32'hA2);
      repeat (16) @(posedge clock);
      `CHK("hs_low", 1'b0, horizontal_sync_out)
      hs_req <= 0;
      off_req <= 0;
      repeat (16) @(posedge clock);
      `CHK("cur_on", 1'b1, green_current_output)
      `CHK("hs_idle", 1'b1, horizontal_sync_out)
   endtask
   task automatic t_passthrough;
      int n;
      dot_run <= 0;
      wr(`PMR_A_MUX, 32'h2D);
      rd("gen_pt", `PMR_A_GEN, 32'h03);
      pt_run <= 1;
      vga_pixel_in <= 8'h12;
      hs_req <= 1;
      off_req <= 1;
      n = 0;
      for (int i = 0; i < 16; i++) begin
         @(posedge clock);
         n += int'(shift_clock_out === 1'b1);
      end
      `CHK("shift_stop", 0, n)
      `CHK("pt_red", 8'hA2, red_out)
      `CHK("pt_hs", 1'b0, horizontal_sync_out)
      `CHK("pt_vs", 1'b1, vertical_sync_out)
      `CHK("pt_sel", 1'b0, external_select_out)
   endtask

   task automatic summarize;
      if (error_cnt == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge clock);
      rst_n <= 1;
      t_reset();
      t_soft_reset();
      t_hw_reset();
      t_normal();
      t_sync();
      t_passthrough();
      summarize();
   end
endmodule // tb
